//--- core/cacd_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "cacd_map.vh"
module cacd_decoder (
	input  wire        sys_clk_in,
	input  wire        reset_in,
	input  wire        cmd_valid_in,
	input  wire [7:0]  cla_in,
	input  wire [7:0]  ins_in,
	input  wire [7:0]  p1_in,
	input  wire [7:0]  p2_in,
	input  wire [7:0]  lc_in,
	input  wire        le_present_in,
	input  wire [7:0]  le_in,
	input  wire        data_valid_in,
	input  wire [7:0]  data_in,
	input  wire        mac_done_in,
	input  wire        mac_ok_in,
	input  wire        mac_missing_in,
	input  wire        nv_state_in,
	input  wire        nv_done_in,
	input  wire        nv_fail_in,
	input  wire [7:0]  reg_addr_in,
	input  wire [31:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [31:0] reg_rdata_out,
	output reg         resp_valid_out,
	output reg  [15:0] sw_out,
	output reg  [1:0]  crypt_type_out,
	output reg         crypt_valid_out,
	output reg         cmd_fwd_out,
	output reg         mac_start_out,
	output reg         nv_prog_out,
	output wire        busy_out,
	output wire        card_disabled_out
);
	// ****************************************************************
	// states and command kinds
	// ****************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_DEC  = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_MAC  = 3'h3;
	localparam ST_NV   = 3'h4;
	localparam ST_CMP  = 3'h5;
	localparam K_DIS   = 2'h0;
	localparam K_AUTH  = 2'h1;
	localparam K_GEN   = 2'h2;
	localparam K_OTHER = 2'h3;

	reg  [2:0]  state_r;
	reg  [1:0]  kind_r;
	reg  [7:0]  cla_r;
	reg  [7:0]  ins_r;
	reg  [7:0]  p1_r;
	reg  [7:0]  p2_r;
	reg  [7:0]  lc_r;
	reg         le_pres_r;
	reg  [7:0]  le_r;
	reg  [7:0]  cnt_r;
	reg  [3:0]  idx_r;
	reg         mism_r;
	reg  [5:0]  ctrl_r;
	reg  [31:0] exp_lo_r;
	reg  [31:0] exp_hi_r;
	reg  [15:0] last_sw_r;
	reg         auth_ok_r;
	reg         nv_set_r;
	reg  [1:0]  type_nxt;
	wire [7:0]  mem_rdata;
	wire        nv_ready;
	wire        disabled;

	assign busy_out          = (state_r != ST_IDLE) || !nv_ready;
	assign card_disabled_out = disabled;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function [1:0] cmd_kind;
		input [7:0] cla;
		input [7:0] ins;
		begin
			if ((cla == `CACD_CLA_SM_MAC || cla == `CACD_CLA_SM_ENC) &&
			    ins == `CACD_INS_DISABLE) begin
				cmd_kind = K_DIS;
			end else if (cla == `CACD_CLA_ISO &&
			             ins == `CACD_INS_EXTAUTH) begin
				cmd_kind = K_AUTH;
			end else if (cla == `CACD_CLA_PROP &&
			             ins == `CACD_INS_CRYPTGEN) begin
				cmd_kind = K_GEN;
			end else begin
				cmd_kind = K_OTHER;
			end
		end
	endfunction

	function [7:0] exp_byte;
		input [3:0]  k;
		input [63:0] exp;
		begin
			exp_byte = exp[8'h3F - {k[2:0], 3'h0} -: 8];
		end
	endfunction

	// success word, optionally downgraded to a warning
	function [15:0] ok_word;
		input [5:0] ctrl;
		begin
			if (!ctrl[`CACD_CTRL_WARN_EN]) begin
				ok_word = `CACD_SW_OK;
			end else if (ctrl[`CACD_CTRL_WARN_SEL]) begin
				ok_word = `CACD_SW_WARN_CORR;
			end else begin
				ok_word = `CACD_SW_WARN_NOINFO;
			end
		end
	endfunction

	// ****************************************************************
	// cryptogram type decision
	// ****************************************************************
	always @* begin
		if (ctrl_r[`CACD_CTRL_OVR_EN]) begin
			type_nxt = ctrl_r[`CACD_CTRL_OVR_LSB +: 2];
		end else begin
			type_nxt = p1_r[7:6];
		end
	end

	cacd_byte_mem u_mem (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (state_r == ST_DATA && data_valid_in),
		.wr_addr_in  (cnt_r[3:0]),
		.wr_data_in  (data_in),
		.rd_addr_in  (idx_r),
		.rd_data_out (mem_rdata)
	);

	cacd_nv_flag u_nv (
		.sys_clk_in  (sys_clk_in),
		.reset_in    (reset_in),
		.nv_state_in (nv_state_in),
		.set_in      (nv_set_r),
		.flag_out    (disabled),
		.ready_out   (nv_ready)
	);

	// ****************************************************************
	// command sequencer
	// ****************************************************************
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_r         <= ST_IDLE;
			kind_r          <= K_OTHER;
			cla_r           <= 8'h00;
			ins_r           <= 8'h00;
			p1_r            <= 8'h00;
			p2_r            <= 8'h00;
			lc_r            <= 8'h00;
			le_pres_r       <= 1'b0;
			le_r            <= 8'h00;
			cnt_r           <= 8'h00;
			idx_r           <= 4'h0;
			mism_r          <= 1'b0;
			auth_ok_r       <= 1'b0;
			nv_set_r        <= 1'b0;
			resp_valid_out  <= 1'b0;
			sw_out          <= 16'h0000;
			crypt_type_out  <= 2'h0;
			crypt_valid_out <= 1'b0;
			cmd_fwd_out     <= 1'b0;
			mac_start_out   <= 1'b0;
			nv_prog_out     <= 1'b0;
		end else begin
			resp_valid_out  <= 1'b0;
			crypt_valid_out <= 1'b0;
			cmd_fwd_out     <= 1'b0;
			mac_start_out   <= 1'b0;
			nv_prog_out     <= 1'b0;
			nv_set_r        <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (cmd_valid_in && nv_ready) begin
					cla_r     <= cla_in;
					ins_r     <= ins_in;
					p1_r      <= p1_in;
					p2_r      <= p2_in;
					lc_r      <= lc_in;
					le_pres_r <= le_present_in;
					le_r      <= le_in;
					cnt_r     <= 8'h00;
					idx_r     <= 4'h0;
					mism_r    <= 1'b0;
					kind_r    <= cmd_kind(cla_in, ins_in);
					state_r   <= ST_DEC;
				end
			end
			ST_DEC: begin
				state_r        <= ST_IDLE;
				resp_valid_out <= 1'b1;
				case (kind_r)
				K_DIS: begin
					if (p1_r != `CACD_P_ZERO ||
					    p2_r != `CACD_P_ZERO) begin
						sw_out <= `CACD_SW_BAD_P1P2;
					end else if (le_pres_r ||
					             lc_r == 8'h00) begin
						sw_out <= `CACD_SW_SM_MISSING;
					end else begin
						resp_valid_out <= 1'b0;
						state_r        <= ST_DATA;
					end
				end
				K_AUTH: begin
					if (p1_r != `CACD_P_ZERO ||
					    p2_r != `CACD_P_ZERO) begin
						sw_out <= `CACD_SW_BAD_P1P2;
					end else if (le_pres_r ||
					             lc_r < `CACD_AUTH_LC_MIN ||
					             lc_r > `CACD_AUTH_LC_MAX) begin
						sw_out <= `CACD_SW_WRONG_LEN;
					end else if (ctrl_r[`CACD_CTRL_BLOCKED]) begin
						sw_out <= `CACD_SW_AUTH_BLOCK;
					end else begin
						resp_valid_out <= 1'b0;
						state_r        <= ST_DATA;
					end
				end
				K_GEN: begin
					if (p2_r != `CACD_P_ZERO ||
					    p1_r[5:0] != 6'h00 ||
					    p1_r[7:6] == `CACD_TYPE_REFERRAL) begin
						sw_out <= `CACD_SW_BAD_P1P2;
					end else if (!le_pres_r ||
					             le_r != `CACD_LE_ZERO) begin
						sw_out <= `CACD_SW_WRONG_LEN;
					end else if (lc_r == 8'h00) begin
						sw_out          <= `CACD_SW_OK;
						crypt_type_out  <= type_nxt;
						crypt_valid_out <= 1'b1;
					end else begin
						resp_valid_out <= 1'b0;
						state_r        <= ST_DATA;
					end
				end
				default: begin
					if (ins_r == `CACD_INS_SELECT && disabled) begin
						sw_out <= `CACD_SW_NOT_SUPP;
					end else begin
						resp_valid_out <= 1'b0;
						cmd_fwd_out    <= 1'b1;
					end
				end
				endcase
			end
			ST_DATA: begin
				if (data_valid_in) begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r + 8'h01 == lc_r) begin
						case (kind_r)
						K_DIS: begin
							mac_start_out <= 1'b1;
							state_r       <= ST_MAC;
						end
						K_AUTH: begin
							state_r <= ST_CMP;
						end
						default: begin
							sw_out          <= `CACD_SW_OK;
							crypt_type_out  <= type_nxt;
							crypt_valid_out <= 1'b1;
							resp_valid_out  <= 1'b1;
							state_r         <= ST_IDLE;
						end
						endcase
					end
				end
			end
			ST_MAC: begin
				if (mac_done_in) begin
					if (mac_missing_in) begin
						sw_out         <= `CACD_SW_SM_MISSING;
						resp_valid_out <= 1'b1;
						state_r        <= ST_IDLE;
					end else if (!mac_ok_in) begin
						sw_out         <= `CACD_SW_SM_BAD;
						resp_valid_out <= 1'b1;
						state_r        <= ST_IDLE;
					end else if (disabled) begin
						sw_out         <= ok_word(ctrl_r);
						resp_valid_out <= 1'b1;
						state_r        <= ST_IDLE;
					end else begin
						nv_prog_out <= 1'b1;
						state_r     <= ST_NV;
					end
				end
			end
			ST_NV: begin
				if (nv_done_in) begin
					resp_valid_out <= 1'b1;
					state_r        <= ST_IDLE;
					if (nv_fail_in) begin
						sw_out <= `CACD_SW_MEM_FAIL;
					end else begin
						nv_set_r <= 1'b1;
						sw_out   <= ok_word(ctrl_r);
					end
				end
			end
			ST_CMP: begin
				// read data trail the address by one cycle
				idx_r <= idx_r + 4'h1;
				if (idx_r != 4'h0 &&
				    mem_rdata != exp_byte(idx_r - 4'h1,
				                          {exp_hi_r, exp_lo_r})) begin
					mism_r <= 1'b1;
				end
				if (idx_r == `CACD_CRYPT_BYTES) begin
					resp_valid_out <= 1'b1;
					state_r        <= ST_IDLE;
					if (mism_r || mem_rdata != exp_byte(4'h7,
					    {exp_hi_r, exp_lo_r})) begin
						sw_out    <= `CACD_SW_AUTH_FAIL;
						auth_ok_r <= 1'b0;
					end else begin
						sw_out    <= `CACD_SW_OK;
						auth_ok_r <= 1'b1;
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// register port
	// ****************************************************************
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			ctrl_r        <= `CACD_CTRL_RESET;
			exp_lo_r      <= 32'h00000000;
			exp_hi_r      <= 32'h00000000;
			last_sw_r     <= 16'h0000;
			reg_rdata_out <= 32'h00000000;
		end else begin
			if (resp_valid_out) begin
				last_sw_r <= sw_out;
			end
			if (reg_wr_in) begin
				case (reg_addr_in)
				`CACD_REG_CTRL:   ctrl_r   <= reg_wdata_in[5:0];
				`CACD_REG_EXP_LO: exp_lo_r <= reg_wdata_in;
				`CACD_REG_EXP_HI: exp_hi_r <= reg_wdata_in;
				default:          ctrl_r   <= ctrl_r;
				endcase
			end
			reg_rdata_out <= 32'h00000000;
			if (reg_rd_in) begin
				case (reg_addr_in)
				`CACD_REG_CTRL:   reg_rdata_out <= {26'h0, ctrl_r};
				`CACD_REG_EXP_LO: reg_rdata_out <= exp_lo_r;
				`CACD_REG_EXP_HI: reg_rdata_out <= exp_hi_r;
				`CACD_REG_STATUS: reg_rdata_out <= {26'h0,
					crypt_type_out, 1'b0, busy_out, auth_ok_r, disabled};
				`CACD_REG_LASTSW: reg_rdata_out <= {16'h0, last_sw_r};
				default:          reg_rdata_out <= 32'h00000000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- core/cacd_map.vh
`ifndef CACD_MAP_VH
`define CACD_MAP_VH
// ****************************************************************
// command coding
// ****************************************************************
`define CACD_CLA_SM_MAC   8'h8C
`define CACD_CLA_SM_ENC   8'h84
`define CACD_INS_DISABLE  8'h16
`define CACD_CLA_ISO      8'h00
`define CACD_INS_EXTAUTH  8'h82
`define CACD_CLA_PROP     8'h80
`define CACD_INS_CRYPTGEN 8'hAE
`define CACD_INS_SELECT   8'hA4
`define CACD_P_ZERO       8'h00
`define CACD_LE_ZERO      8'h00
`define CACD_AUTH_LC_MIN  8'h08
`define CACD_AUTH_LC_MAX  8'h10
`define CACD_CRYPT_BYTES  4'h8
// ****************************************************************
// reference-control / cryptogram type codes
// ****************************************************************
`define CACD_TYPE_DECLINED 2'h0
`define CACD_TYPE_APPROVAL 2'h1
`define CACD_TYPE_ONLINE   2'h2
`define CACD_TYPE_REFERRAL 2'h3
// ****************************************************************
// status words
// ****************************************************************
`define CACD_SW_OK          16'h9000
`define CACD_SW_WARN_NOINFO 16'h6200
`define CACD_SW_WARN_CORR   16'h6281
`define CACD_SW_AUTH_FAIL   16'h6300
`define CACD_SW_MEM_FAIL    16'h6581
`define CACD_SW_WRONG_LEN   16'h6700
`define CACD_SW_AUTH_BLOCK  16'h6983
`define CACD_SW_SM_MISSING  16'h6987
`define CACD_SW_SM_BAD      16'h6988
`define CACD_SW_NOT_SUPP    16'h6A81
`define CACD_SW_BAD_P1P2    16'h6A86
// ****************************************************************
// register map
// ****************************************************************
`define CACD_REG_CTRL   8'h00
`define CACD_REG_EXP_LO 8'h04
`define CACD_REG_EXP_HI 8'h08
`define CACD_REG_STATUS 8'h0C
`define CACD_REG_LASTSW 8'h10
`define CACD_CTRL_WARN_EN  0
`define CACD_CTRL_WARN_SEL 1
`define CACD_CTRL_BLOCKED  2
`define CACD_CTRL_OVR_EN   3
`define CACD_CTRL_OVR_LSB  4
`define CACD_CTRL_RESET    6'h00
`define CACD_NV_LOAD_CYC   2'h3
`endif

//--- core/cacd_byte_mem.v
`timescale 1ns/10ps
`default_nettype none
module cacd_byte_mem (
	input  wire       sys_clk_in,
	input  wire       wr_en_in,
	input  wire [3:0] wr_addr_in,
	input  wire [7:0] wr_data_in,
	input  wire [3:0] rd_addr_in,
	output reg  [7:0] rd_data_out
);
	reg [7:0] mem_r [0:15];

	always @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_r[rd_addr_in];
	end
endmodule
`default_nettype wire

//--- core/cacd_nv_flag.v
`timescale 1ns/10ps
`default_nettype none
`include "cacd_map.vh"
module cacd_nv_flag (
	input  wire sys_clk_in,
	input  wire reset_in,
	input  wire nv_state_in,
	input  wire set_in,
	output reg  flag_out,
	output wire ready_out
);
	reg       sync1_r;
	reg       sync2_r;
	reg [1:0] load_cnt_r;

	assign ready_out = (load_cnt_r == `CACD_NV_LOAD_CYC);

	// ****************************************************************
	// reload stored state after reset
	// ****************************************************************
	always @(posedge sys_clk_in) begin
		sync1_r <= nv_state_in;
		sync2_r <= sync1_r;
		if (reset_in) begin
			flag_out   <= 1'b0;
			load_cnt_r <= 2'h0;
		end else begin
			if (!ready_out) begin
				load_cnt_r <= load_cnt_r + 2'h1;
			end
			if (set_in) begin
				flag_out <= 1'b1;
			end else if (load_cnt_r == 2'h2) begin
				flag_out <= sync2_r;
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/cacd_decoder_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cacd_decoder_chk (
	input wire logic        sys_clk_in,
	input wire logic        reset_in,
	input wire logic        cmd_valid_in,
	input wire logic [7:0]  cla_in,
	input wire logic [7:0]  ins_in,
	input wire logic [7:0]  p1_in,
	input wire logic [7:0]  p2_in,
	input wire logic [7:0]  lc_in,
	input wire logic        le_present_in,
	input wire logic        nv_done_in,
	input wire logic        nv_fail_in,
	input wire logic        resp_valid_out,
	input wire logic [15:0] sw_out,
	input wire logic        crypt_valid_out,
	input wire logic        cmd_fwd_out,
	input wire logic        mac_start_out,
	input wire logic        nv_prog_out,
	input wire logic        busy_out,
	input wire logic        card_disabled_out
);
	wire tk = cmd_valid_in && !busy_out;
	wire p0 = (p1_in | p2_in) == 8'h00;
	wire dis = (cla_in == 8'h8C || cla_in == 8'h84) && ins_in == 8'h16;
	wire aut = cla_in == 8'h00 && ins_in == 8'h82;
	wire gen = cla_in == 8'h80 && ins_in == 8'hAE;
	wire sel = tk && cla_in == 8'h00 && ins_in == 8'hA4 && card_disabled_out;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	AST_SEL_REFUSED: assert property (sel |-> ##2 resp_valid_out &&
		sw_out == 16'h6A81) else $error("select not refused");
	AST_SEL_QUIET: assert property (sel |-> ##1
		(!cmd_fwd_out && !nv_prog_out && !mac_start_out)[*3])
		else $error("select caused an action");
	AST_DIS_PARAM: assert property (tk && dis && !p0 && lc_in != 8'h00 &&
		!le_present_in |-> ##2 resp_valid_out && sw_out == 16'h6A86)
		else $error("disable bad p1 p2 not refused");
	AST_DIS_DONE: assert property (nv_done_in && !nv_fail_in |=>
		resp_valid_out && sw_out inside {16'h9000, 16'h6200, 16'h6281})
		else $error("disable success status wrong");
	AST_NV_FAIL: assert property (nv_done_in && nv_fail_in |=>
		resp_valid_out && sw_out == 16'h6581) else $error("memory fail status");
	AST_AUTH_LEN: assert property (tk && aut && p0 && (lc_in < 8'h08 ||
		lc_in > 8'h10 || le_present_in) |-> ##2 resp_valid_out &&
		sw_out == 16'h6700) else $error("auth length not refused");
	AST_AUTH_PARAM: assert property (tk && aut && !p0 |-> ##2
		resp_valid_out && sw_out == 16'h6A86) else $error("auth p1 p2");
	AST_GEN_RSVD: assert property (tk && gen && p2_in == 8'h00 &&
		(p1_in[5:0] != 6'h00 || p1_in[7:6] == 2'h3) |-> ##2 resp_valid_out
		&& sw_out == 16'h6A86 && !crypt_valid_out)
		else $error("reserved control not refused");
	AST_CRYPT_RESP: assert property (crypt_valid_out |-> resp_valid_out &&
		!cmd_fwd_out) else $error("cryptogram without response");
	AST_DIS_STICKY: assert property (card_disabled_out |=>
		card_disabled_out) else $error("disabled state lost");
endmodule
bind cacd_decoder cacd_decoder_chk i_chk (.*);
`default_nettype wire

//--- testbench/cacd_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cacd_far_model (
	input wire logic clk_in,
	input wire logic mac_start_in,
	input wire logic nv_prog_in,
	input wire logic ok_cfg_in,
	input wire logic miss_cfg_in,
	input wire logic fail_cfg_in,
	input wire logic slow_in,
	output var logic mac_done_out,
	output var logic mac_ok_out,
	output var logic mac_missing_out,
	output var logic nv_done_out,
	output var logic nv_fail_out,
	output var logic nv_state_out
);
	int mc = 0;
	int nc = 0;
	initial {mac_done_out, mac_ok_out, mac_missing_out} = 3'h0;
	initial {nv_done_out, nv_fail_out, nv_state_out} = 3'h0;
	// verdict levels toggle outside the done pulse
	always @(posedge clk_in) begin
		mc <= mac_start_in ? (slow_in ? 7 : 1) : (mc > 0 ? mc - 1 : 0);
		nc <= nv_prog_in ? (slow_in ? 9 : 2) : (nc > 0 ? nc - 1 : 0);
		mac_done_out <= mc == 1;
		mac_ok_out <= mc == 1 ? ok_cfg_in : ~mac_ok_out;
		mac_missing_out <= mc == 1 ? miss_cfg_in : ~mac_missing_out;
		nv_done_out <= nc == 1;
		nv_fail_out <= nc == 1 ? fail_cfg_in : ~nv_fail_out;
		if (nc == 1 && !fail_cfg_in) begin
			nv_state_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        sys_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        cmd_valid_in = 1'b0, le_present_in = 1'b0;
	logic        data_valid_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic [7:0]  cla_in = 8'h00, ins_in = 8'h00, p1_in = 8'h00;
	logic [7:0]  p2_in = 8'h00, lc_in = 8'h00, le_in = 8'h00;
	logic [7:0]  data_in = 8'h00, reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
	logic        ok_c = 1'b1, miss_c = 1'b0, fail_c = 1'b0, slow_c = 1'b0;
	wire logic   mac_done_in, mac_ok_in, mac_missing_in;
	wire logic   nv_state_in, nv_done_in, nv_fail_in;
	logic [15:0] sw_out;
	logic [1:0]  crypt_type_out;
	logic        resp_valid_out, crypt_valid_out, cmd_fwd_out, busy_out;
	logic        mac_start_out, nv_prog_out, card_disabled_out, rd_d = 1'b0;
	int          n_fail = 0, checks_done = 0, n_seen = 0, t;
	int          seed = 32'h2576;
	logic [19:0] eq[$];
	logic [31:0] rq[$];
	logic [63:0] exp_v;
	always #5 sys_clk_in = ~sys_clk_in;
	cacd_decoder i_dut (.*);
	cacd_far_model i_far (.clk_in(sys_clk_in), .mac_start_in(mac_start_out),
		.nv_prog_in(nv_prog_out), .ok_cfg_in(ok_c), .miss_cfg_in(miss_c),
		.fail_cfg_in(fail_c), .slow_in(slow_c), .mac_done_out(mac_done_in),
		.mac_ok_out(mac_ok_in), .mac_missing_out(mac_missing_in),
		.nv_done_out(nv_done_in), .nv_fail_out(nv_fail_in),
		.nv_state_out(nv_state_in));
	// ****************************************************************
	// checking
	// ****************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", s, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin : mon
		logic [19:0] e;
		if (rd_d) chk(reg_rdata_out, rq.pop_front(), "register read");
		rd_d <= reg_rd_in;
		if (resp_valid_out === 1'b1 || cmd_fwd_out === 1'b1) begin
			e = eq.pop_front();
			n_seen++;
			chk(cmd_fwd_out, e[19], "forward");
			chk(crypt_valid_out, e[18], "crypt valid");
			if (e[18]) chk(crypt_type_out, e[17:16], "crypt type");
			if (!e[19]) chk(sw_out, e[15:0], "status word");
		end
	end
	initial begin
		#400000;
		n_fail++;
		end_sim;
	end
	// ****************************************************************
	// bus tasks
	// ****************************************************************
	task rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= wr;
		reg_rd_in <= !wr;
		if (!wr) rq.push_back(d);
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
	endtask
	// p1 and p2 are sent as given, reserved bits included; the data byte count nd is given apart from lc
	task apdu(input logic [7:0] c, i, a, b, l, input logic lp,
		input int nd, input logic [19:0] e);
		int k;
		int t0;
		eq.push_back(e);
		t0 = n_seen;
		@(posedge sys_clk_in);
		for (k = 0; k < 50 && busy_out !== 1'b0; k++) @(posedge sys_clk_in);
		{cla_in, ins_in, p1_in, p2_in, lc_in} <= {c, i, a, b, l};
		le_present_in <= lp;
		cmd_valid_in <= 1'b1;
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		for (k = 0; k < nd; k++) begin
			data_in <= (k < 8 && i == 8'h82) ? exp_v[63 - 8 * k -: 8]
				: 8'($random(seed));
			data_valid_in <= 1'b1;
			@(posedge sys_clk_in);
		end
		data_valid_in <= 1'b0;
		for (k = 0; k < 200 && n_seen == t0; k++) @(posedge sys_clk_in);
		chk(n_seen, t0 + 1, "response count");
		// let flags set by the response settle before callers look
		@(posedge sys_clk_in);
	endtask
	function logic [19:0] ex(input logic [15:0] s);
		return {4'h0, s};
	endfunction
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		rw(0, 8'h00, 32'h0);
		rw(0, 8'h10, 32'h0);
		rw(1, 8'h14, 32'hFFFF_FFFF);
		rw(0, 8'h14, 32'h0);
		exp_v = {$random(seed), $random(seed)};
		rw(1, 8'h08, exp_v[63:32]);
		rw(1, 8'h04, exp_v[31:0]);
		rw(0, 8'h08, exp_v[63:32]);
		apdu(8'h00, 8'hA4, 8'h04, 8'h00, 8'h00, 0, 0, 20'h80000);
		$display("test registers and select done");
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h08, 0, 8, ex(16'h9000));
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h10, 0, 16, ex(16'h9000));
		exp_v[0] = ~exp_v[0];
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h08, 0, 8, ex(16'h6300));
		exp_v[0] = ~exp_v[0];
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h07, 0, 0, ex(16'h6700));
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h11, 0, 0, ex(16'h6700));
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h08, 1, 0, ex(16'h6700));
		apdu(8'h00, 8'h82, 8'h01, 8'h00, 8'h08, 0, 0, ex(16'h6A86));
		apdu(8'h00, 8'h82, 8'h00, 8'h01, 8'h08, 0, 0, ex(16'h6A86));
		rw(1, 8'h00, 32'h4);
		apdu(8'h00, 8'h82, 8'h00, 8'h00, 8'h08, 0, 8, ex(16'h6983));
		rw(1, 8'h00, 32'h0);
		$display("test authenticate done");
		for (t = 0; t < 3; t++)
			apdu(8'h80, 8'hAE, {t[1:0], 6'h0}, 8'h00, 8'h05, 1, 5,
				{2'b01, t[1:0], 16'h9000});
		apdu(8'h80, 8'hAE, 8'hC0, 8'h00, 8'h05, 1, 5, ex(16'h6A86));
		apdu(8'h80, 8'hAE, 8'h41, 8'h00, 8'h05, 1, 5, ex(16'h6A86));
		apdu(8'h80, 8'hAE, 8'h40, 8'h00, 8'h05, 0, 5, ex(16'h6700));
		le_in <= 8'h01;
		apdu(8'h80, 8'hAE, 8'h40, 8'h00, 8'h05, 1, 5, ex(16'h6700));
		le_in <= 8'h00;
		apdu(8'h80, 8'hAE, 8'h00, 8'h00, 8'h00, 1, 0,
			{2'b01, 2'h0, 16'h9000});
		for (t = 0; t < 4; t++) begin
			rw(1, 8'h00, {26'h0, t[1:0], 4'h8});
			apdu(8'h80, 8'hAE, 8'h80, 8'h00, 8'h05, 1, 5,
				{2'b01, t[1:0], 16'h9000});
		end
		rw(1, 8'h00, 32'h0);
		$display("test cryptogram generation done");
		apdu(8'h8C, 8'h16, 8'h01, 8'h00, 8'h04, 0, 0, ex(16'h6A86));
		apdu(8'h84, 8'h16, 8'h00, 8'h80, 8'h04, 0, 0, ex(16'h6A86));
		miss_c <= 1'b1;
		apdu(8'h8C, 8'h16, 8'h00, 8'h00, 8'h04, 0, 4, ex(16'h6987));
		miss_c <= 1'b0;
		ok_c <= 1'b0;
		apdu(8'h8C, 8'h16, 8'h00, 8'h00, 8'h04, 0, 4, ex(16'h6988));
		ok_c <= 1'b1;
		fail_c <= 1'b1;
		apdu(8'h84, 8'h16, 8'h00, 8'h00, 8'h04, 0, 4, ex(16'h6581));
		fail_c <= 1'b0;
		slow_c <= 1'b1;
		chk(card_disabled_out, 1'b0, "disabled before");
		apdu(8'h8C, 8'h16, 8'h00, 8'h00, 8'h08, 0, 8, ex(16'h9000));
		chk(card_disabled_out, 1'b1, "disabled after");
		apdu(8'h84, 8'h16, 8'h00, 8'h00, 8'h04, 0, 4, ex(16'h9000));
		rw(1, 8'h00, 32'h1);
		apdu(8'h8C, 8'h16, 8'h00, 8'h00, 8'h04, 0, 4, ex(16'h6200));
		rw(1, 8'h00, 32'h3);
		apdu(8'h8C, 8'h16, 8'h00, 8'h00, 8'h04, 0, 4, ex(16'h6281));
		rw(1, 8'h00, 32'h0);
		rw(0, 8'h0C, 32'h31);
		rw(0, 8'h10, 32'h6281);
		apdu(8'h00, 8'hA4, 8'h04, 8'h00, 8'h00, 0, 0, ex(16'h6A81));
		$display("test card disable done");
		@(posedge sys_clk_in);
		reset_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		apdu(8'h00, 8'hA4, 8'h04, 8'h00, 8'h00, 0, 0, ex(16'h6A81));
		chk(card_disabled_out, 1'b1, "disabled after reset");
		$display("test reset persistence done");
		chk(eq.size(), 0, "pending responses");
		end_sim;
	end
endmodule
`default_nettype wire
